//--- inc/iprc_defs.svh
// iprc_defs.svh: offsets, field positions and reset values of the interrupt priority logic
`ifndef IPRC_DEFS_SVH
`define IPRC_DEFS_SVH
`define IPRC_ADDR_CMD        1'h0
`define IPRC_ADDR_MASK       1'h1
`define IPRC_BIT_INIT        4
`define IPRC_BIT_KIND        3
`define IPRC_BIT_ROTATE      7
`define IPRC_BIT_SELECT      6
`define IPRC_BIT_EOI         5
`define IPRC_BIT_ENABLE_SPECIAL_MASK        6
`define IPRC_BIT_SMM         5
`define IPRC_BIT_POLL        2
`define IPRC_BIT_RDREG       1
`define IPRC_BIT_RDSEL       0
`define IPRC_MASK_RESET      8'h00
`define IPRC_LOWEST_RESET    3'h7
`define IPRC_POLL_ACTIVE     8'h80
`define IPRC_ACKS_TWO_CYCLE  2'h2
`define IPRC_ACKS_THREE_CYCLE 2'h3
`endif

//--- inc/iprc_pkg.sv
// iprc_pkg.sv: types shared by the interrupt priority logic
package iprc_pkg;
    // one host access at the parallel port
    typedef struct packed {
        logic       write;      // write strobe
        logic       read;       // read strobe
        logic       addr;       // address bit
        logic [7:0] data;       // write data
    } iprc_bus_type;
    // resolution result
    typedef struct packed {
        logic       valid;      // a level wins
        logic [2:0] level;      // its number
    } iprc_pick_type;
    // acknowledge sequencer states, one-hot
    typedef enum logic [2:0] {
        IPRC_IDLE = 3'b001,
        IPRC_BUSY = 3'b010,
        IPRC_LAST = 3'b100
    } iprc_ack_type;
endpackage

//--- design/iprc_resolver.sv
// iprc_resolver.sv: rotating priority search over eight levels
`timescale 1ns/1ps
module iprc_resolver (
    input  wire logic [7:0]          vector_in,   // candidate bits
    input  wire logic [2:0]          lowest_in,   // lowest priority level
    output iprc_pkg::iprc_pick_type  pick_out     // highest candidate
);
    // rotate so that the level above lowest sits at bit 0
    wire logic [15:0] doubled = {vector_in, vector_in};
    wire logic [2:0]  start   = lowest_in + 3'h1;
    wire logic [7:0]  rotated = doubled[start +: 8];
    logic [2:0] offset;   // position of first set bit
    // priority encode from the highest priority end
    always_comb begin
        offset = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (rotated[i]) begin
                offset = 3'(i);
            end
        end
    end
    assign pick_out.valid = |vector_in;
    assign pick_out.level = start + offset;
endmodule

//--- design/iprc_mask_store.sv
// iprc_mask_store.sv: mask register, cleared by reset and by the init word
`timescale 1ns/1ps
`include "iprc_defs.svh"
module iprc_mask_store (
    input  wire logic       clock_in,    // system clock
    input  wire logic       rst_n_in,    // synchronised reset
    input  wire logic       clear_in,    // init word clears
    input  wire logic       load_in,     // mask word write
    input  wire logic [7:0] data_in,     // new mask bits
    output logic      [7:0] mask_out     // stored mask
);
    // all eight bits load together from one mask word; each bit masks only its own level
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_out <= `IPRC_MASK_RESET;
        end else if (clear_in) begin
            mask_out <= `IPRC_MASK_RESET;
        end else if (load_in) begin
            mask_out <= data_in;           // [RULE1]
        end
    end
endmodule

//--- design/iprc_core.sv
// iprc_core.sv: command decode, priority resolution and end of interrupt handling
//
// Operation
// (RULE1) eight mask bits, one per level
// (RULE2) reset order: level 0 highest, 7 lowest
// (RULE3) acknowledge sets highest unmasked pending service bit
// (RULE4) service bit holds until end of interrupt
// (RULE5) service bit blocks same and lower levels
// (RULE6) non-specific command clears highest service bit
// (RULE7) specific command clears the named level
// (RULE8) special mask: non-specific spares masked levels
// (RULE9) automatic end on final acknowledge pulse
// (RULE10) rotate on non-specific end of interrupt
// (RULE11) rotate-on-automatic flag set and cleared
// (RULE12) set priority names the lowest level
// (RULE13) rotate on specific end of interrupt
// (RULE14) special mask ignores service bits for blocking
// (RULE15) enable bit gates special mask changes
// (RULE16) host ends cascaded interrupts twice
// (RULE17) host prefers specific ends in rotated modes
// (RULE18) first init word restarts and clears masks
// (RULE19) read command selects request or service register
// (RULE20) poll makes next read an acknowledge
// (RULE21) address-one read returns the mask
// (RULE22) write decode by address and bits 4:3
// (RULE23) init clears flag, service bits, priority
`timescale 1ns/1ps
`include "iprc_defs.svh"
module iprc_core (
    input  wire logic       clock_in,        // 50 MHz system clock
    input  wire logic       rst_n_in,        // asynchronous reset, active low
    input  wire logic       write_in,        // one-cycle write strobe
    input  wire logic       read_in,         // one-cycle read strobe
    input  wire logic       address_bit_in,  // command/mask select
    input  wire logic [7:0] data_in,         // write data
    input  wire logic [7:0] request_in,      // request register from sensing
    input  wire logic       ack_pulse_in,    // one cycle per acknowledge trailing edge
    input  wire logic       auto_eoi_in,     // automatic end of interrupt mode
    input  wire logic       two_cycle_in,    // 1: two acknowledges, 0: three
    output logic      [7:0] read_data_out,   // registered read data
    output logic            interrupt_out,   // request to the processor
    output logic      [7:0] in_service_out,  // in-service register
    output logic      [7:0] request_clr_out, // request bit taken, one-cycle
    output logic            freeze_out       // acknowledge or poll in progress
);
    // reset synchroniser; only the second stage is used
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire logic rst_n = rst_sync_r;

    iprc_pkg::iprc_bus_type bus;   // bundled host access
    assign bus = '{write: write_in, read: read_in, addr: address_bit_in, data: data_in};

    // state registers
    logic [7:0] service_r;       // in-service bits
    logic [2:0] lowest_r;        // level of lowest priority
    logic       special_r;       // special mask mode
    logic       rot_auto_r;      // rotate on automatic end flag
    logic       read_isr_r;      // 1: status reads return service bits
    logic       poll_r;          // next read is a poll acknowledge
    logic [1:0] ack_count_r;     // acknowledges seen in this sequence
    logic [2:0] ack_level_r;     // level frozen at first acknowledge
    logic       ack_hit_r;       // first acknowledge found a request
    iprc_pkg::iprc_ack_type ack_state_r;
    logic [7:0] mask;

    // write decode [RULE22]
    wire logic cmd_wr   = bus.write && (bus.addr == `IPRC_ADDR_CMD);
    wire logic init_wr  = cmd_wr && bus.data[`IPRC_BIT_INIT];                          // [RULE18]
    wire logic prio_wr  = cmd_wr && !bus.data[`IPRC_BIT_INIT] && !bus.data[`IPRC_BIT_KIND];
    wire logic mode_wr  = cmd_wr && !bus.data[`IPRC_BIT_INIT] && bus.data[`IPRC_BIT_KIND];
    wire logic mask_wr  = bus.write && (bus.addr == `IPRC_ADDR_MASK);
    wire logic rot_bit  = bus.data[`IPRC_BIT_ROTATE];
    wire logic sel_bit  = bus.data[`IPRC_BIT_SELECT];
    wire logic eoi_bit  = bus.data[`IPRC_BIT_EOI];
    wire logic [2:0] lvl_field = bus.data[2:0];
    wire logic [7:0] lvl_onehot = 8'h01 << lvl_field;

    iprc_mask_store u_mask (
        .clock_in (clock_in),
        .rst_n_in (rst_n),
        .clear_in (init_wr),
        .load_in  (mask_wr),
        .data_in  (bus.data),
        .mask_out (mask)
    );

    // priority resolution on requests and on service bits
    wire logic [7:0] pending = request_in & ~mask;                                     // [RULE3]
    iprc_pkg::iprc_pick_type req_pick;
    iprc_pkg::iprc_pick_type srv_pick;
    iprc_pkg::iprc_pick_type eoi_pick;
    iprc_resolver u_req (.vector_in(pending),   .lowest_in(lowest_r), .pick_out(req_pick));
    iprc_resolver u_srv (.vector_in(service_r), .lowest_in(lowest_r), .pick_out(srv_pick));
    // in special mask mode masked service bits are not candidates for clearing
    wire logic [7:0] eoi_cand = special_r ? (service_r & ~mask) : service_r;           // [RULE8]
    iprc_resolver u_eoi (.vector_in(eoi_cand),  .lowest_in(lowest_r), .pick_out(eoi_pick));

    // priority rank of a level: 0 is highest
    wire logic [2:0] req_rank = req_pick.level - lowest_r - 3'h1;
    wire logic [2:0] srv_rank = srv_pick.level - lowest_r - 3'h1;
    // blocking of other levels by service bits only outside special mask mode
    wire logic req_ok = req_pick.valid &&
        (special_r || !srv_pick.valid || (req_rank < srv_rank));                       // [RULE5] [RULE14]
    // in special mask mode a pending level whose own bit is in service still waits
    wire logic [7:0] spec_pend = pending & ~service_r;
    iprc_pkg::iprc_pick_type spec_pick;
    iprc_resolver u_spc (.vector_in(spec_pend), .lowest_in(lowest_r), .pick_out(spec_pick));
    wire logic grant_ok      = special_r ? spec_pick.valid : req_ok;
    wire logic [2:0] grant_lv = special_r ? spec_pick.level : req_pick.level;

    // acknowledge sequencing
    wire logic ack_first  = ack_pulse_in && (ack_state_r == iprc_pkg::IPRC_IDLE);
    wire logic [1:0] acks_needed = two_cycle_in ? `IPRC_ACKS_TWO_CYCLE
                                                : `IPRC_ACKS_THREE_CYCLE;
    wire logic ack_final  = ack_pulse_in && (ack_count_r + 2'h1 == acks_needed);
    wire logic poll_rd    = read_in && poll_r;                                         // [RULE20]
    wire logic take       = (ack_first || poll_rd) && grant_ok;                        // [RULE3]
    wire logic auto_end   = ack_final && auto_eoi_in && ack_hit_r;                     // [RULE9]

    // end of interrupt decode [RULE6] [RULE7] [RULE10] [RULE13]
    wire logic ns_eoi   = prio_wr && !sel_bit && eoi_bit;
    wire logic sp_eoi   = prio_wr && sel_bit && eoi_bit;
    wire logic set_prio = prio_wr && rot_bit && sel_bit;                               // [RULE12]
    wire logic [7:0] ns_clear = eoi_pick.valid ? (8'h01 << eoi_pick.level) : 8'h00;
    wire logic [7:0] auto_clear = 8'h01 << ack_level_r;
    wire logic [7:0] clear_bits = (ns_eoi ? ns_clear : 8'h00) |
                                  (sp_eoi ? lvl_onehot : 8'h00) |
                                  (auto_end ? auto_clear : 8'h00);
    wire logic [7:0] set_bits = take ? (8'h01 << grant_lv) : 8'h00;

    // next value of the service bits; a new grant wins over a clear
    wire logic [7:0] service_nxt = init_wr ? 8'h00 : ((service_r & ~clear_bits) | set_bits);

    // service register update [RULE4] [RULE23]
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            service_r <= 8'h00;
        end else begin
            service_r <= service_nxt;
        end
    end

    // priority rotation; set priority wins, then explicit rotations, then automatic
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            lowest_r <= `IPRC_LOWEST_RESET;                                            // [RULE2]
        end else if (init_wr) begin
            lowest_r <= `IPRC_LOWEST_RESET;                                            // [RULE23]
        end else if (set_prio) begin
            lowest_r <= lvl_field;                                                     // [RULE12] [RULE13]
        end else if (ns_eoi && rot_bit && eoi_pick.valid) begin
            lowest_r <= eoi_pick.level;                                                // [RULE10]
        end else if (auto_end && rot_auto_r) begin
            lowest_r <= ack_level_r;                                                   // [RULE11]
        end
    end

    // mode flags
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            special_r  <= 1'b0;
            rot_auto_r <= 1'b0;
            read_isr_r <= 1'b0;
        end else if (init_wr) begin
            special_r  <= 1'b0;                                                        // [RULE18]
            rot_auto_r <= 1'b0;                                                        // [RULE23]
            read_isr_r <= 1'b0;
        end else begin
            if (mode_wr && bus.data[`IPRC_BIT_ENABLE_SPECIAL_MASK]) begin
                special_r <= bus.data[`IPRC_BIT_SMM];                                  // [RULE15]
            end
            if (prio_wr && !sel_bit && !eoi_bit) begin
                rot_auto_r <= rot_bit;                                                 // [RULE11]
            end
            if (mode_wr && bus.data[`IPRC_BIT_RDREG]) begin
                read_isr_r <= bus.data[`IPRC_BIT_RDSEL];                               // [RULE19]
            end
        end
    end

    // poll request held until the next read
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            poll_r <= 1'b0;
        end else if (init_wr || read_in) begin
            poll_r <= 1'b0;
        end else if (mode_wr) begin
            poll_r <= bus.data[`IPRC_BIT_POLL];                                        // [RULE20]
        end
    end

    // acknowledge sequence: count pulses, freeze level at the first
    logic [1:0]             ack_count_nxt;
    iprc_pkg::iprc_ack_type ack_state_nxt;
    always_comb begin
        ack_count_nxt = ack_count_r;
        ack_state_nxt = ack_state_r;
        case (ack_state_r)
            iprc_pkg::IPRC_IDLE: begin
                if (ack_pulse_in) begin
                    ack_count_nxt = 2'h1;
                    ack_state_nxt = iprc_pkg::IPRC_BUSY;
                end
            end
            iprc_pkg::IPRC_BUSY: begin
                if (ack_final) begin
                    ack_state_nxt = iprc_pkg::IPRC_LAST;
                end else if (ack_pulse_in) begin
                    ack_count_nxt = ack_count_r + 2'h1;
                end
            end
            iprc_pkg::IPRC_LAST: begin
                ack_count_nxt = 2'h0;
                ack_state_nxt = iprc_pkg::IPRC_IDLE;
            end
            default: begin
                ack_count_nxt = 2'h0;
                ack_state_nxt = iprc_pkg::IPRC_IDLE;
            end
        endcase
    end
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ack_count_r <= 2'h0;
            ack_state_r <= iprc_pkg::IPRC_IDLE;
        end else begin
            ack_count_r <= ack_count_nxt;
            ack_state_r <= ack_state_nxt;
        end
    end

    // level taken at the first acknowledge, used by the automatic end
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ack_level_r <= 3'h0;
            ack_hit_r   <= 1'b0;
        end else if (ack_first) begin
            ack_level_r <= grant_lv;
            ack_hit_r   <= grant_ok;
        end
    end

    // read data: poll word beats status; address one returns the mask
    wire logic [7:0] poll_word = grant_ok ? (`IPRC_POLL_ACTIVE | {5'h00, grant_lv}) : 8'h00;
    wire logic [7:0] status    = read_isr_r ? service_r : request_in;
    wire logic [7:0] rd_sel    = poll_r ? poll_word :
                                 (bus.addr == `IPRC_ADDR_MASK) ? mask : status;        // [RULE19] [RULE21]

    // registered outputs
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            read_data_out   <= 8'h00;
            interrupt_out   <= 1'b0;
            in_service_out  <= 8'h00;
            request_clr_out <= 8'h00;
            freeze_out      <= 1'b0;
        end else begin
            if (read_in) begin
                read_data_out <= rd_sel;
            end
            interrupt_out   <= grant_ok && !init_wr;                                   // [RULE5]
            in_service_out  <= service_nxt;
            request_clr_out <= set_bits;
            freeze_out      <= (ack_state_nxt != iprc_pkg::IPRC_IDLE) || poll_r;
        end
    end

    // service bit must appear one cycle after a granted acknowledge
    a_ack_sets_bit: assert property (@(posedge clock_in) disable iff (!rst_n)
        take |=> service_r[$past(grant_lv)]) else $error("grant did not set bit"); // [RULE3]
    // init word empties service register and restores order
    a_init_clears: assert property (@(posedge clock_in) disable iff (!rst_n)
        init_wr |=> (service_r == 8'h00) && (lowest_r == 3'h7) && !special_r && !rot_auto_r)
        else $error("init did not clear state"); // [RULE23]
    // specific end clears the named level when no grant collides
    a_specific_eoi: assert property (@(posedge clock_in) disable iff (!rst_n)
        (sp_eoi && !take) |=> !service_r[$past(lvl_field)])
        else $error("specific end left bit set"); // [RULE7]
    // masked level is never granted
    a_mask_blocks: assert property (@(posedge clock_in) disable iff (!rst_n)
        take |-> !mask[grant_lv]) else $error("masked level granted"); // [RULE1]
    // set priority moves the lowest level
    a_set_priority: assert property (@(posedge clock_in) disable iff (!rst_n)
        (set_prio && !init_wr) |=> lowest_r == $past(lvl_field))
        else $error("priority not set"); // [RULE12]
    // special mask follows enable bit
    a_special_mode: assert property (@(posedge clock_in) disable iff (!rst_n)
        (mode_wr && !init_wr && bus.data[`IPRC_BIT_ENABLE_SPECIAL_MASK]) |=> special_r == $past(data_in[5]))
        else $error("special mask not taken"); // [RULE15]
    // outside special mask a grant outranks every service bit
    a_nested_block: assert property (@(posedge clock_in) disable iff (!rst_n)
        (take && !special_r && srv_pick.valid) |-> req_rank < srv_rank)
        else $error("nested blocking broken"); // [RULE5]
    // automatic end clears the acknowledged level
    a_auto_eoi: assert property (@(posedge clock_in) disable iff (!rst_n)
        (auto_end && !take && !init_wr) |=> !service_r[$past(ack_level_r)])
        else $error("automatic end failed"); // [RULE9]
endmodule

//--- verification/iprc_host_model.sv
// iprc_host_model.sv: host processor issuing command writes, reads and acknowledges
`timescale 1ns/1ps
module iprc_host_model (
    input  wire logic       clock_in,  // system clock
    input  wire logic [7:0] rdata_in,  // read data from the block
    output logic            write_out, // write strobe
    output logic            read_out,  // read strobe
    output logic            addr_out,  // address bit
    output logic [7:0]      data_out,  // write data
    output logic            ack_out    // acknowledge trailing edge pulse
);
    // quiet bus at time zero
    initial begin
        write_out = 1'b0;
        read_out  = 1'b0;
        addr_out  = 1'b0;
        data_out  = 8'h00;
        ack_out   = 1'b0;
    end
    // one write; the released bus shows the inverse so stale data never passes
    task automatic wr(input logic a, input logic [7:0] d);
        @(negedge clock_in);
        write_out = 1'b1;
        addr_out  = a;
        data_out  = d;
        @(negedge clock_in);
        write_out = 1'b0;
        addr_out  = ~a;
        data_out  = ~d;
    endtask
    // one read, the answer taken after the registered data has landed
    task automatic rd(input logic a, output logic [7:0] d);
        @(negedge clock_in);
        read_out = 1'b1;
        addr_out = a;
        @(negedge clock_in);
        read_out = 1'b0;
        addr_out = ~a;
        @(negedge clock_in);
        d = rdata_in;
    endtask
    // n acknowledge pulses, each followed by an idle cycle
    task automatic ack(input int n);
        repeat (n) begin
            @(negedge clock_in);
            ack_out = 1'b1;
            @(negedge clock_in);
            ack_out = 1'b0;
        end
    endtask
    // ends are sent specific since rotation can upset nesting
    // a single controller here, so each end is sent once only
    task automatic end_of_interrupt(input logic [2:0] lvl);
        wr(1'b0, {5'b01100, lvl});
    endtask
endmodule

//--- verification/interrupt_priority_command_logic_test.sv
// interrupt_priority_command_logic_test.sv: self-checking bench of the priority logic
`timescale 1ns/1ps
module interrupt_priority_command_logic_test;
    logic       clock_in;   // 50 MHz clock
    logic       rst_n_in;   // reset, active low
    logic [7:0] request_r;  // request levels driven by the bench
    logic       auto_r;     // automatic end mode
    logic       two_r;      // two-pulse acknowledge sequence
    logic       wr_w;       // host write strobe
    logic       rd_w;       // host read strobe
    logic       a_w;        // host address bit
    logic [7:0] d_w;        // host write data
    logic       ack_w;      // host acknowledge pulse
    logic [7:0] rdata;      // read data
    logic       irq;        // interrupt output
    logic [7:0] in_service_register;        // service bits
    logic [7:0] got;        // last read value
    logic [7:0] clr_w;      // request taken pulse
    logic       frz_w;      // freeze level
    logic [7:0] clr_seen;   // last non-zero request taken pulse
    int         n_mismatch; // mismatches seen
    int         checks;     // comparisons made
    iprc_core DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .write_in(wr_w),
        .read_in(rd_w), .address_bit_in(a_w), .data_in(d_w), .request_in(request_r),
        .ack_pulse_in(ack_w), .auto_eoi_in(auto_r), .two_cycle_in(two_r),
        .read_data_out(rdata), .interrupt_out(irq), .in_service_out(in_service_register),
        .request_clr_out(clr_w), .freeze_out(frz_w));
    iprc_host_model host (.clock_in(clock_in), .rdata_in(rdata), .write_out(wr_w),
        .read_out(rd_w), .addr_out(a_w), .data_out(d_w), .ack_out(ack_w));
    // free-running clock
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    // the taken pulse stands one cycle only, so hold it for a later compare
    always @(posedge clock_in) begin
        if (clr_w != 8'h00) begin
            clr_seen <= clr_w;
        end
    end
    // one comparison, reported at once on a mismatch
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // let registered outputs catch up with a state change
    task automatic settle(input logic [7:0] r);
        @(negedge clock_in);
        request_r = r;
        repeat (3) @(negedge clock_in);
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // mask store, independent bits and readback without a command
    task automatic t_mask;
        host.rd(1'b1, got);
        check(got, 8'h00);
        host.wr(1'b1, 8'hFE);
        host.rd(1'b1, got);
        check(got, 8'hFE);
        settle(8'h02);
        check({7'h00, irq}, 8'h00);
        host.wr(1'b1, 8'hFD);
        settle(8'h03);
        check({7'h00, irq}, 8'h01);
        host.wr(1'b1, 8'h00);
    endtask
    // nested grants, blocking, status reads, both end forms
    task automatic t_nested;
        settle(8'h28);
        host.ack(3);
        check(in_service_register, 8'h08);
        check(clr_seen, 8'h08);
        settle(8'h20);
        check({7'h00, irq}, 8'h00);
        settle(8'h04);
        check({7'h00, irq}, 8'h01);
        host.ack(3);
        check(in_service_register, 8'h0C);
        host.wr(1'b0, 8'h0B);
        host.rd(1'b0, got);
        check(got, 8'h0C);
        host.wr(1'b0, 8'h0A);
        host.rd(1'b0, got);
        check(got, 8'h04);
        host.wr(1'b0, 8'h20);
        settle(8'h00);
        check(in_service_register, 8'h08);
        host.end_of_interrupt(3'h3);
        settle(8'h00);
        check(in_service_register, 8'h00);
    endtask
    // poll read acts as an acknowledge
    task automatic t_poll;
        settle(8'h40);
        host.wr(1'b0, 8'h0C);
        settle(8'h40);
        check({7'h00, frz_w}, 8'h01);
        host.rd(1'b0, got);
        check(got, 8'h86);
        check(in_service_register, 8'h40);
        check(clr_seen, 8'h40);
        check({7'h00, frz_w}, 8'h00);
        host.end_of_interrupt(3'h6);
    endtask
    // rotation by end commands and set priority
    task automatic t_rotate;
        settle(8'h10);
        host.ack(3);
        host.wr(1'b0, 8'hA0);
        settle(8'h21);
        check(in_service_register, 8'h00);
        host.ack(3);
        check(in_service_register, 8'h20);
        host.wr(1'b0, 8'hC7);
        settle(8'h41);
        check(in_service_register, 8'h20);
        host.ack(3);
        check(in_service_register, 8'h21);
        host.wr(1'b0, 8'hE5);
        settle(8'h41);
        host.ack(3);
        check(in_service_register, 8'h41);
        host.end_of_interrupt(3'h6);
        host.end_of_interrupt(3'h0);
        host.wr(1'b0, 8'hC7);
    endtask
    // automatic end in both sequence lengths, with and without rotation
    task automatic t_auto;
        host.wr(1'b0, 8'h80);
        auto_r = 1'b1;
        two_r  = 1'b1;
        settle(8'h08);
        host.ack(1);
        check(in_service_register, 8'h08);
        host.ack(1);
        check(in_service_register, 8'h00);
        host.wr(1'b0, 8'h00);
        two_r = 1'b0;
        settle(8'h02);
        host.ack(2);
        check(in_service_register, 8'h02);
        host.ack(1);
        check(in_service_register, 8'h00);
        auto_r = 1'b0;
        settle(8'h24);
        host.ack(3);
        check(in_service_register, 8'h20);
        host.end_of_interrupt(3'h5);
        host.wr(1'b0, 8'hC7);
    endtask
    // special mask mode entry, exit and its end-command rule
    task automatic t_special;
        settle(8'h08);
        host.ack(3);
        host.wr(1'b0, 8'h68);
        host.wr(1'b1, 8'h08);
        settle(8'h20);
        check({7'h00, irq}, 8'h01);
        host.ack(3);
        host.wr(1'b0, 8'h20);
        settle(8'h20);
        check(in_service_register, 8'h08);
        host.wr(1'b0, 8'h08);
        settle(8'h20);
        check({7'h00, irq}, 8'h01);
        host.wr(1'b0, 8'h48);
        settle(8'h20);
        check({7'h00, irq}, 8'h00);
    endtask
    // first init word clears mask and service state
    task automatic t_init;
        host.wr(1'b0, 8'h10);
        settle(8'h00);
        check(in_service_register, 8'h00);
        host.rd(1'b1, got);
        check(got, 8'h00);
    endtask
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        n_mismatch++;
        final_report;
    end
    // main sequence
    initial begin
        n_mismatch = 0;
        checks     = 0;
        rst_n_in   = 1'b0;
        request_r  = 8'h00;
        auto_r     = 1'b0;
        two_r      = 1'b0;
        repeat (8) @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clock_in);
        t_mask;
        t_nested;
        t_poll;
        t_rotate;
        t_auto;
        t_special;
        t_init;
        final_report;
    end
endmodule
